// file: rtl/fault_irq_pkg.sv
// package: register map, field layout and carrier types of the fault interrupt enable block
`default_nettype none
package fault_irq_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_BOOST_EN      = 8'h0A;
    localparam logic [7:0]  IDX_CHANNEL_EN    = 8'h0C;
    localparam logic [7:0]  IDX_FAULT_STATUS  = 8'h12;
    localparam logic [7:0]  IDX_FAULT_MASK    = 8'h13;

    // reset values; enable words as read back, mask as one bit per event
    localparam logic [15:0] BOOST_EN_RST      = 16'hA028;
    localparam logic [15:0] CHANNEL_EN_RST    = 16'h00AA;
    localparam logic [9:0]  FAULT_MASK_RST    = 10'h3FF;

    // two-bit field codes
    localparam logic [1:0]  FIELD_WR_OFF      = 2'h1;
    localparam logic [1:0]  FIELD_WR_ON       = 2'h3;
    localparam logic [1:0]  FIELD_RD_OFF      = 2'h0;
    localparam logic [1:0]  FIELD_RD_ON       = 2'h2;

    // field counts; boost field k sits at bits 2k+3:2k+2, channel field k at 2k+1:2k
    localparam int          BOOST_FIELDS      = 7;
    localparam int          CHANNEL_FIELDS    = 4;
    localparam int          FAULT_EVENTS      = 10;
    localparam int          GLOBAL_FIELD      = 3;

    // boost fault sources, msb first in field order
    typedef struct packed {
        logic thermal_shutdown;
        logic current_resistor_short;
        logic string_config_resistor_missing;
        logic mode_resistor_missing;
        logic frequency_resistor_missing;
        logic boost_overcurrent;
        logic boost_overvoltage_high;
    } boost_faults_t;

    // channel fault sources, msb first in field order
    typedef struct packed {
        logic serial_timeout;
        logic bad_string_config;
        logic string_fault;
    } channel_faults_t;

    typedef struct packed {
        logic [6:0]  boost_en;
        logic [3:0]  channel_en;
        logic [9:0]  status;
        logic [9:0]  mask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
    } fault_irq_state_t;
endpackage : fault_irq_pkg
`default_nettype wire

// file: rtl/fault_interrupt_enable_regs.sv
// fault interrupt enable registers with latched fault status, apb slave
//
// Contract
// - boost enable at index 0Ah, resets A028h
// - channel enable at index 0Ch, resets AAh
// - field write 1h disables source
// - field write 3h enables source
// - disabled field reads 0h
// - enabled field reads 2h
// - bits 13-12 gate current resistor short
// - bits 11-10 gate string resistor missing
// - bits 9-8 gate mode resistor missing
// - bits 7-6 gate frequency resistor missing
// - bits 5-4 gate boost overcurrent
// - bits 3-2 gate overvoltage; 1-0 reserved
// - channel bits 5-4 gate serial timeout
// - channel bits 3-2 gate bad strings
// - channel bits 1-0 gate string faults
// - status and clear bits together clear
//
// The APB register port was decided locally.
`default_nettype none
module fault_interrupt_enable_regs
    import fault_irq_pkg::*;
(
    input  wire logic            MCLK,          // 200 MHz clock
    input  wire logic            SRST,          // synchronous reset, active high
    input  wire logic            PSEL,          // apb select
    input  wire logic            PENABLE,       // apb access phase
    input  wire logic            PWRITE,        // apb direction
    input  wire logic [7:0]      PADDR,         // apb byte address
    input  wire logic [31:0]     PWDATA,        // apb write data
    output logic      [31:0]     PRDATA,        // apb read data
    output logic                 PREADY,        // apb ready
    output logic                 PSLVERR,       // apb error, unmapped address
    input  wire boost_faults_t   BOOST_FAULT,   // boost fault levels
    input  wire channel_faults_t CHANNEL_FAULT, // channel fault levels
    output logic                 IRQ            // interrupt, high active level
);

    fault_irq_state_t state_reg;
    fault_irq_state_t state_next;

    logic [9:0] event_vec;
    logic [9:0] enable_vec;
    logic [9:0] clear_vec;
    logic       access;
    logic       commit;
    logic       wr_commit;
    logic       hit_boost;
    logic       hit_channel;
    logic       hit_status;
    logic       hit_mask;
    logic       hit_any;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    assign access      = PSEL && PENABLE;
    assign commit      = access && state_reg.pready;
    assign wr_commit   = commit && PWRITE;
    assign hit_boost   = PADDR == 8'(IDX_BOOST_EN * 4);
    assign hit_channel = PADDR == 8'(IDX_CHANNEL_EN * 4);
    assign hit_status  = PADDR == 8'(IDX_FAULT_STATUS * 4);
    assign hit_mask    = PADDR == 8'(IDX_FAULT_MASK * 4);
    assign hit_any     = hit_boost || hit_channel || hit_status || hit_mask;

    ////////////////////////////////////////////////////////////////////////////
    // event order: boost sources in bits 9:3, channel sources in bits 2:0

    assign event_vec = {BOOST_FAULT, CHANNEL_FAULT};

    assign enable_vec = {state_reg.boost_en, state_reg.channel_en[2:0]};

    // paired clear: status bit 2j+1 and clear bit 2j both one
    generate
        for (genvar j = 0; j < FAULT_EVENTS; j++) begin : g_clear
            assign clear_vec[j] = wr_commit && hit_status && PWDATA[2*j+1] && PWDATA[2*j];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // field helpers

    // coded field update; other codes keep the state
    function automatic logic field_update(input logic cur, input logic [1:0] code);
        logic res;
        res = cur;
        if (code == FIELD_WR_OFF) begin
            res = 1'b0;
        end else if (code == FIELD_WR_ON) begin
            res = 1'b1;
        end
        return res;
    endfunction : field_update

    function automatic logic [1:0] field_read(input logic en);
        return en ? FIELD_RD_ON : FIELD_RD_OFF;
    endfunction : field_read

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [31:0] rd;
        rd         = 32'h0000_0000;
        state_next = state_reg;

        // one wait state: ready rises on the second access cycle, drops after the commit
        state_next.pready  = access && !state_reg.pready;
        state_next.pslverr = access && !state_reg.pready && !hit_any;

        if (hit_boost) begin
            // reserved bits 1-0 stay zero on read
            for (int k = 0; k < BOOST_FIELDS; k++) begin
                rd[2*k+2 +: 2] = field_read(state_reg.boost_en[k]);
            end
        end else if (hit_channel) begin
            for (int k = 0; k < CHANNEL_FIELDS; k++) begin
                rd[2*k +: 2] = field_read(state_reg.channel_en[k]);
            end
        end else if (hit_status) begin
            for (int j = 0; j < FAULT_EVENTS; j++) begin
                rd[2*j+1] = state_reg.status[j];
            end
        end else if (hit_mask) begin
            for (int j = 0; j < FAULT_EVENTS; j++) begin
                rd[2*j+1] = state_reg.mask[j];
            end
        end
        // read data is captured while waiting, so it stands at the commit edge
        state_next.prdata = (access && !state_reg.pready && !PWRITE) ? rd : 32'h0000_0000;

        if (wr_commit && hit_boost) begin
            for (int k = 0; k < BOOST_FIELDS; k++) begin
                state_next.boost_en[k] = field_update(state_reg.boost_en[k], PWDATA[2*k+2 +: 2]);
            end
        end
        if (wr_commit && hit_channel) begin
            for (int k = 0; k < CHANNEL_FIELDS; k++) begin
                state_next.channel_en[k] = field_update(state_reg.channel_en[k], PWDATA[2*k +: 2]);
            end
        end
        if (wr_commit && hit_mask) begin
            for (int j = 0; j < FAULT_EVENTS; j++) begin
                state_next.mask[j] = PWDATA[2*j+1];
            end
        end

        // a fault in the clearing cycle survives: set wins over clear
        state_next.status = (state_reg.status & ~clear_vec) | event_vec;

        state_next.irq = state_next.channel_en[GLOBAL_FIELD] &&
                         |(state_next.status & state_next.mask &
                           {state_next.boost_en, state_next.channel_en[2:0]});

        if (SRST) begin
            // reset enables derived from the readback reset words
            for (int k = 0; k < BOOST_FIELDS; k++) begin
                state_next.boost_en[k] = BOOST_EN_RST[2*k+3];
            end
            for (int k = 0; k < CHANNEL_FIELDS; k++) begin
                state_next.channel_en[k] = CHANNEL_EN_RST[2*k+1];
            end
            state_next.status  = '0;
            state_next.mask    = FAULT_MASK_RST;
            state_next.prdata  = 32'h0000_0000;
            state_next.pready  = 1'b0;
            state_next.pslverr = 1'b0;
            state_next.irq     = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        state_reg <= state_next;
    end

    assign PRDATA  = state_reg.prdata;
    assign PREADY  = state_reg.pready;
    assign PSLVERR = state_reg.pslverr;
    assign IRQ     = state_reg.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_boost_reset_val: assert property (
        @(posedge MCLK) $past(SRST) |-> state_reg.boost_en == 7'h63)
        else $error("boost enable reset value wrong");

    a_channel_reset_val: assert property (
        @(posedge MCLK) $past(SRST) |-> state_reg.channel_en == 4'hF && !IRQ)
        else $error("channel enable reset value wrong");

    a_field_disable: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_commit && hit_boost && PWDATA[15:14] == 2'h1 |=> !state_reg.boost_en[6])
        else $error("write of 1h did not disable field");

    a_field_enable: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_commit && hit_channel && PWDATA[5:4] == 2'h3 |=> state_reg.channel_en[2])
        else $error("write of 3h did not enable field");

    a_read_format: assert property (
        @(posedge MCLK) disable iff (SRST)
        commit && !PWRITE && (hit_boost || hit_channel) |->
        (PRDATA & 32'hFFFF_5555) == 32'h0000_0000)
        else $error("enable readback format wrong");

    a_field_keep: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_commit && hit_boost && !PWDATA[4] |=> $stable(state_reg.boost_en[1]))
        else $error("ignored code changed the field");

    a_global_gate: assert property (
        @(posedge MCLK) disable iff (SRST)
        !state_reg.channel_en[GLOBAL_FIELD] |-> !IRQ)
        else $error("interrupt raised while globally disabled");

    a_pair_clear: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_commit && hit_status && PWDATA[1:0] == 2'h3 && !CHANNEL_FAULT.string_fault
        |=> !state_reg.status[0])
        else $error("paired clear did not clear status");

    a_half_clear: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status[0] && !(wr_commit && hit_status && PWDATA[1:0] == 2'h3)
        |=> state_reg.status[0])
        else $error("status lost without a paired clear");

    a_irq_cause: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status[0] && state_reg.mask[0] && state_reg.channel_en[0] &&
        state_reg.channel_en[GLOBAL_FIELD] |-> IRQ)
        else $error("enabled string fault did not raise interrupt");

    a_pready_wait: assert property (
        @(posedge MCLK) disable iff (SRST)
        access && !PREADY |=> PREADY ##1 !PREADY)
        else $error("ready did not follow one wait state");

    a_chan_disable: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_commit && hit_channel && PWDATA[1:0] == 2'h1 |=> !state_reg.channel_en[0])
        else $error("write of 1h did not disable channel field");

    a_boost_enable: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_commit && hit_boost && PWDATA[3:2] == 2'h3 |=> state_reg.boost_en[0])
        else $error("write of 3h did not enable boost field");

    a_read_off: assert property (
        @(posedge MCLK) disable iff (SRST)
        commit && !PWRITE && hit_boost && !state_reg.boost_en[4] |-> PRDATA[11:10] == 2'h0)
        else $error("disabled field did not read 0h");

    a_read_on: assert property (
        @(posedge MCLK) disable iff (SRST)
        commit && !PWRITE && hit_channel && state_reg.channel_en[3] |-> PRDATA[7:6] == 2'h2)
        else $error("enabled field did not read 2h");

    a_boost_reserved: assert property (
        @(posedge MCLK) disable iff (SRST)
        commit && !PWRITE && hit_boost |-> PRDATA[1:0] == 2'h0 && PRDATA[31:16] == 16'h0000)
        else $error("boost reserved bits not zero");

    a_chan_reserved: assert property (
        @(posedge MCLK) disable iff (SRST)
        commit && !PWRITE && hit_channel |-> PRDATA[31:8] == 24'h00_0000)
        else $error("channel reserved bits not zero");

    a_chan_keep: assert property (
        @(posedge MCLK) disable iff (SRST)
        wr_commit && hit_channel && !PWDATA[6] |=> $stable(state_reg.channel_en[GLOBAL_FIELD]))
        else $error("ignored code changed the global field");

    a_gate_cur_short: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h100 && !state_reg.boost_en[5] |-> !IRQ)
        else $error("disabled current resistor short raised interrupt");

    a_gate_string_res: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h080 && !state_reg.boost_en[4] |-> !IRQ)
        else $error("disabled string resistor fault raised interrupt");

    a_gate_mode_res: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h040 && !state_reg.boost_en[3] |-> !IRQ)
        else $error("disabled mode resistor fault raised interrupt");

    a_gate_freq_res: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h020 && !state_reg.boost_en[2] |-> !IRQ)
        else $error("disabled frequency resistor fault raised interrupt");

    a_gate_overcurrent: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h010 && !state_reg.boost_en[1] |-> !IRQ)
        else $error("disabled overcurrent raised interrupt");

    a_gate_overvoltage: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h008 && !state_reg.boost_en[0] |-> !IRQ)
        else $error("disabled overvoltage raised interrupt");

    a_gate_bus_timeout: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h004 && !state_reg.channel_en[2] |-> !IRQ)
        else $error("disabled serial timeout raised interrupt");

    a_gate_bad_strings: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h002 && !state_reg.channel_en[1] |-> !IRQ)
        else $error("disabled bad string config raised interrupt");

    a_gate_string_fault: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h001 && !state_reg.channel_en[0] |-> !IRQ)
        else $error("disabled string fault raised interrupt");

    a_mask_gate: assert property (
        @(posedge MCLK) disable iff (SRST)
        state_reg.status == 10'h001 && !state_reg.mask[0] |-> !IRQ)
        else $error("masked string fault raised interrupt");

    a_irq_needs_cause: assert property (
        @(posedge MCLK) disable iff (SRST)
        IRQ |-> state_reg.channel_en[GLOBAL_FIELD] && |(state_reg.status & state_reg.mask & enable_vec))
        else $error("interrupt without an enabled latched fault");

    a_set_wins: assert property (
        @(posedge MCLK) disable iff (SRST)
        CHANNEL_FAULT.string_fault |=> state_reg.status[0])
        else $error("fault did not latch its status");

    a_err_unmapped: assert property (
        @(posedge MCLK) disable iff (SRST)
        commit && !hit_any |-> PSLVERR)
        else $error("unmapped access without error");

    a_err_mapped: assert property (
        @(posedge MCLK) disable iff (SRST)
        commit && hit_any |-> !PSLVERR)
        else $error("mapped access flagged as error");

    a_ready_pulse: assert property (
        @(posedge MCLK) disable iff (SRST)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

endmodule : fault_interrupt_enable_regs
`default_nettype wire

// file: test/fault_interrupt_enable_regs_bench.sv
// testbench: apb register walk and fault interrupt gating of the fault interrupt enable block
`default_nettype none
module fault_interrupt_enable_regs_bench;
    import fault_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_BOOST = {IDX_BOOST_EN[5:0], 2'b00};
    localparam logic [7:0] A_CHAN  = {IDX_CHANNEL_EN[5:0], 2'b00};
    localparam logic [7:0] A_STAT  = {IDX_FAULT_STATUS[5:0], 2'b00};
    localparam logic [7:0] A_MASK  = {IDX_FAULT_MASK[5:0], 2'b00};
    logic        MCLK    = 1'b0;
    logic        SRST    = 1'b1;
    logic        PSEL    = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE  = 1'b0;
    logic [7:0]  PADDR   = 8'h00;
    logic [31:0] PWDATA  = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        IRQ;
    logic [9:0]  flt     = 10'h000;
    logic [15:0] en_exp[2];
    logic [7:0]  en_addr[2];
    int          miscompares = 0;
    int          n_tests     = 0;
    int          cyc         = 0;
    logic [31:0] q;
    logic        e;

    fault_interrupt_enable_regs DUT (
        .MCLK          (MCLK),
        .SRST          (SRST),
        .PSEL          (PSEL),
        .PENABLE       (PENABLE),
        .PWRITE        (PWRITE),
        .PADDR         (PADDR),
        .PWDATA        (PWDATA),
        .PRDATA        (PRDATA),
        .PREADY        (PREADY),
        .PSLVERR       (PSLVERR),
        .BOOST_FAULT   (boost_faults_t'(flt[9:3])),
        .CHANNEL_FAULT (channel_faults_t'(flt[2:0])),
        .IRQ           (IRQ)
    );

    initial begin
        forever #2.5 MCLK = ~MCLK;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    // the whole run needs about 700 cycles; a hang is cut well beyond that
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
            miscompares++;
        end
    endtask : chk

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
        chk({31'h0, e}, 32'h0);
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge MCLK);
    endtask : idle

    task automatic irq_is(input logic v);
        idle(3);
        chk({31'h0, IRQ}, {31'h0, v});
    endtask : irq_is

    // write one field code and track the expected readback
    task automatic set_field(input int s, input int p, input logic on);
        wr(en_addr[s], (on ? 32'h3 : 32'h1) << p);
        en_exp[s][p+1] = on;
    endtask : set_field

    task automatic pulse(input int j);
        flt <= 10'h001 << j;
        idle(2);
        flt <= 10'h000;
        idle(1);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    initial begin
        en_exp[0] = BOOST_EN_RST;
        en_exp[1] = CHANNEL_EN_RST;
        en_addr[0] = A_BOOST;
        en_addr[1] = A_CHAN;
        idle(16);
        SRST <= 1'b0;
        rdc(A_BOOST, 32'h0000A028);
        rdc(A_CHAN, 32'h000000AA);
        rdc(A_STAT, 32'h0);
        rdc(A_MASK, 32'h000AAAAA);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q[30:0]}, 32'h80000000);
        for (int k = 0; k < BOOST_FIELDS + CHANNEL_FIELDS; k++) begin
            set_field(k < BOOST_FIELDS ? 0 : 1, k < BOOST_FIELDS ? 2 * k + 2 : 2 * (k - BOOST_FIELDS), 1'b0);
            rdc(en_addr[k < BOOST_FIELDS ? 0 : 1], {16'h0, en_exp[k < BOOST_FIELDS ? 0 : 1]});
            set_field(k < BOOST_FIELDS ? 0 : 1, k < BOOST_FIELDS ? 2 * k + 2 : 2 * (k - BOOST_FIELDS), 1'b1);
            rdc(en_addr[k < BOOST_FIELDS ? 0 : 1], {16'h0, en_exp[k < BOOST_FIELDS ? 0 : 1]});
        end
        // codes 0h and 2h, reserved bits ignored
        wr(A_BOOST, 32'h0000AAAB);
        wr(A_CHAN, 32'h0000FF22);
        rdc(A_BOOST, 32'h0000AAA8);
        rdc(A_CHAN, 32'h000000AA);
        // each field gates its own source
        for (int j = 0; j < FAULT_EVENTS; j++) begin
            pulse(j);
            irq_is(1'b1);
            wr(A_STAT, 32'h1 << (2 * j + 1));
            rdc(A_STAT, 32'h1 << (2 * j + 1));
            set_field(j > 2 ? 0 : 1, j > 2 ? 2 * j - 4 : 2 * j, 1'b0);
            irq_is(1'b0);
            set_field(j > 2 ? 0 : 1, j > 2 ? 2 * j - 4 : 2 * j, 1'b1);
            irq_is(1'b1);
            wr(A_STAT, 32'h3 << (2 * j));
            irq_is(1'b0);
            rdc(A_STAT, 32'h0);
        end
        pulse(0);
        set_field(1, 6, 1'b0);
        irq_is(1'b0);
        rdc(A_CHAN, {16'h0, en_exp[1]});
        set_field(1, 6, 1'b1);
        irq_is(1'b1);
        wr(A_MASK, 32'h000AAAA8);
        irq_is(1'b0);
        rdc(A_MASK, 32'h000AAAA8);
        wr(A_MASK, 32'h000FFFFF);
        irq_is(1'b1);
        // a fault still high during the paired clear keeps its status
        flt <= 10'h001;
        wr(A_STAT, 32'h3);
        rdc(A_STAT, 32'h00000002);
        flt <= 10'h000;
        wr(A_STAT, 32'h3);
        irq_is(1'b0);
        end_sim();
    end
endmodule : fault_interrupt_enable_regs_bench
`default_nettype wire
